// ### nts_pkg.sv
package nts_pkg;
  // user side and memory side widths
  localparam int LOCATION_WIDTH = 12;
  localparam int WORD_WIDTH     = 32;
  localparam int LANE_COUNT     = 4;
  localparam int MEM_LOC_W      = 12;
  // 0 = pipelined, 1 = flow-through
  localparam bit FLOWTHROUGH_DEF = 1'b0;
  // command fifo
  localparam int CMD_DEPTH      = 16;
  // read return: bus lag + two sync flops + output flop
  localparam int RD_TAG_LEN     = 5;
  // register map, byte addresses
  localparam int AV_ADDR_W      = 4;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_RD_CNT  = 4'h8;
  localparam logic [3:0] REG_WR_CNT  = 4'hc;
  // control and status field positions and reset values
  localparam int CTRL_RUN_BIT   = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam int STAT_LVL_LSB   = 0;
  localparam int STAT_BUSY_BIT  = 8;
  localparam int STAT_FULL_BIT  = 9;

  // one avalon request as seen by the slave
  typedef struct packed {
    logic [AV_ADDR_W-1:0] address;
    logic                 read;
    logic                 write;
    logic [31:0]          writedata;
    logic [3:0]           byteenable;
  } nts_av_req_t;
endpackage

// ### nts_sram_ctrl.sv
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// command fifo: flop storage, registered full and empty
module nts_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_LVL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH-1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_idx;
  logic [PW-1:0]    rd_idx;
  logic             push;
  logic             pop;
  logic [PW:0]      next_level;

  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_idx];

  always_comb
  begin
    next_level = o_level;
    if (push && !pop)
      next_level = o_level + 1'b1;
    else if (pop && !push)
      next_level = o_level - 1'b1;
  end

  // storage has no reset: contents are only read once written
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wr_idx] <= i_in_data;
  end

  // pointers and flags, full and empty kept as flops for clean ports
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      wr_idx      <= '0;
      rd_idx      <= '0;
      o_level     <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      if (pop)
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      o_level     <= next_level;
      o_in_ready  <= (next_level != FULL_LVL);
      o_out_valid <= (next_level != '0);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// controller top
module nts_sram_ctrl
#(
  parameter int LOCATION_WIDTH = nts_pkg::LOCATION_WIDTH,
  parameter int WORD_WIDTH     = nts_pkg::WORD_WIDTH,
  parameter int LANE_COUNT     = nts_pkg::LANE_COUNT,
  parameter bit FLOWTHROUGH    = nts_pkg::FLOWTHROUGH_DEF
)
(
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_nrst,
  // user command stream
  input  wire logic                       i_cmd_valid,
  output logic                            o_cmd_ready,
  input  wire logic [LOCATION_WIDTH-1:0]  i_user_location,
  input  wire logic                       i_user_read,
  input  wire logic                       i_user_burst_continue,
  input  wire logic [WORD_WIDTH-1:0]      i_user_write_word,
  input  wire logic [LANE_COUNT-1:0]      i_user_byte_mask,
  output logic [WORD_WIDTH-1:0]           o_user_read_word,
  output logic                            o_user_read_valid,
  // avalon-mm slave
  input  wire logic [nts_pkg::AV_ADDR_W-1:0] i_av_address,
  input  wire logic                       i_av_read,
  input  wire logic                       i_av_write,
  input  wire logic [31:0]                i_av_writedata,
  input  wire logic [3:0]                 i_av_byteenable,
  output logic [31:0]                     o_av_readdata,
  output logic                            o_av_waitrequest,
  // memory side
  output logic [nts_pkg::MEM_LOC_W-1:0]   o_memory_location_out,
  output logic                            o_memory_burst_continue,
  output logic [LANE_COUNT-1:0]           o_memory_byte_enables_low,
  output logic                            o_mem_read_write,
  input  wire logic [WORD_WIDTH-1:0]      i_mem_dq,
  output logic [WORD_WIDTH-1:0]           o_mem_dq,
  output logic                            o_mem_dq_oe
);
  import nts_pkg::*;

  localparam int CMD_W = LOCATION_WIDTH + 2 + WORD_WIDTH + LANE_COUNT;
  localparam int LAT   = FLOWTHROUGH ? 1 : 2;

  nts_av_req_t                 av;
  logic                        run;
  logic [31:0]                 rd_count;
  logic [31:0]                 wr_count;
  logic [$clog2(CMD_DEPTH):0]  fifo_level;
  logic                        q_valid;
  logic [CMD_W-1:0]            q_data;
  logic                        issue;
  logic [LOCATION_WIDTH-1:0]   c_loc;
  logic                        c_read;
  logic                        c_cont;
  logic [WORD_WIDTH-1:0]       c_word;
  logic [LANE_COUNT-1:0]       c_mask;
  logic [MEM_LOC_W-1:0]        base_loc;
  logic [MEM_LOC_W-1:0]        load_loc;
  logic [1:0]                  burst_cnt;
  logic [WORD_WIDTH-1:0]       wdata_pipe [2];
  logic [1:0]                  wen_pipe;
  logic [RD_TAG_LEN-1:0]       rd_tag;
  logic [WORD_WIDTH-1:0]       dq_sync1;
  logic [WORD_WIDTH-1:0]       dq_sync2;

  // widen or trim the user location onto the 12 memory pins
  function automatic logic [MEM_LOC_W-1:0] to_mem_loc(input logic [LOCATION_WIDTH-1:0] loc);
    logic [MEM_LOC_W+LOCATION_WIDTH-1:0] wide;
    wide = {{MEM_LOC_W{1'b0}}, loc};
    return wide[MEM_LOC_W-1:0];
  endfunction

  assign av = '{address: i_av_address, read: i_av_read, write: i_av_write,
                writedata: i_av_writedata, byteenable: i_av_byteenable};

  //////////////////////////////////////////////////////////////////////////////
  // command queue; the run bit stalls the drain so the queue can fill
  nts_fifo #(.WIDTH(CMD_W), .DEPTH(CMD_DEPTH)) u_cmd_fifo
  (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_cmd_valid),
    .o_in_ready  (o_cmd_ready),
    .i_in_data   ({i_user_location, i_user_read, i_user_burst_continue,
                   i_user_write_word, i_user_byte_mask}),
    .o_out_valid (q_valid),
    .i_out_ready (run),
    .o_out_data  (q_data),
    .o_level     (fifo_level)
  );

  assign issue = q_valid && run;
  assign {c_loc, c_read, c_cont, c_word, c_mask} = q_data;
  // pin-width copy of the queued location, also seeds the burst counter
  assign load_loc = to_mem_loc(c_loc);

  //////////////////////////////////////////////////////////////////////////////
  // address and control, one command per cycle with no idle between directions
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_memory_location_out     <= '0;
      o_memory_burst_continue   <= 1'b0;
      o_mem_read_write          <= 1'b1;
      o_memory_byte_enables_low <= '1;
      base_loc                  <= '0;
      burst_cnt                 <= 2'h0;
    end
    else if (issue)
    begin
      o_mem_read_write        <= c_read;
      o_memory_burst_continue <= c_cont;
      // lanes enabled only on writes, in the command cycle
      o_memory_byte_enables_low <= c_read ? '1 : ~c_mask;
      if (!c_cont)
      begin
        base_loc              <= load_loc;
        burst_cnt             <= load_loc[1:0];
        o_memory_location_out <= load_loc;
      end
      else
      begin
        // the memory ignores the low bits here; mirror its counter for traces
        burst_cnt             <= burst_cnt + 2'h1;
        o_memory_location_out <= {base_loc[MEM_LOC_W-1:2], burst_cnt + 2'h1};
      end
    end
    else
    begin
      // idle cycle: deselect writes, leave address parked
      o_mem_read_write          <= 1'b1;
      o_memory_burst_continue   <= 1'b0;
      o_memory_byte_enables_low <= '1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write data delay line; stage 0 lines up with the command cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      wdata_pipe[0] <= '0;
      wdata_pipe[1] <= '0;
      wen_pipe      <= 2'h0;
    end
    else
    begin
      wdata_pipe[0] <= c_word;
      wdata_pipe[1] <= wdata_pipe[0];
      wen_pipe      <= {wen_pipe[0], issue && !c_read};
    end
  end

  // bus driver: one or two cycles after the command, released on reads
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_mem_dq    <= '0;
      o_mem_dq_oe <= 1'b0;
    end
    else
    begin
      o_mem_dq    <= wdata_pipe[LAT-1];
      o_mem_dq_oe <= wen_pipe[LAT-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read return: tag ripples alongside the bus lag and the two sync flops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      rd_tag <= '0;
    else
      rd_tag <= {rd_tag[RD_TAG_LEN-2:0], issue && c_read};
  end

  // the pad flop feeds only the second flop
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      dq_sync1 <= '0;
      dq_sync2 <= '0;
    end
    else
    begin
      dq_sync1 <= i_mem_dq;
      dq_sync2 <= dq_sync1;
    end
  end

  // word lands LAT+3 edges after issue; valid stands one cycle, the word holds until the next read
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_user_read_word  <= '0;
      o_user_read_valid <= 1'b0;
    end
    else
    begin
      // bus word stands in the cycle after edge issue+LAT, so the pad flop takes it at
      // issue+LAT+1; sampling one edge sooner would catch the previous bus owner
      o_user_read_valid <= rd_tag[LAT+2];
      if (rd_tag[LAT+2])
        o_user_read_word <= dq_sync2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // traffic counters, read-only to software
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      rd_count <= '0;
      wr_count <= '0;
    end
    else if (issue)
    begin
      if (c_read)
        rd_count <= rd_count + 32'h1;
      else
        wr_count <= wr_count + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle per access, answer on the edge wait drops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      o_av_waitrequest <= 1'b1;
    else
      o_av_waitrequest <= !((av.read || av.write) && o_av_waitrequest);
  end

  // control write takes effect on the same edge the master sees wait low
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      run <= CTRL_RUN_RST;
    else if (av.write && !o_av_waitrequest && av.address == REG_CTRL && av.byteenable[0])
      run <= av.writedata[CTRL_RUN_BIT];
  end

  // read data loaded as wait drops; unmapped offsets read zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      o_av_readdata <= '0;
    else if (av.read && o_av_waitrequest)
    begin
      o_av_readdata <= '0;
      unique case (av.address)
        REG_CTRL:   o_av_readdata[CTRL_RUN_BIT] <= run;
        REG_STATUS:
        begin
          o_av_readdata[STAT_LVL_LSB +: $clog2(CMD_DEPTH)+1] <= fifo_level;
          o_av_readdata[STAT_BUSY_BIT] <= q_valid || (rd_tag != '0) || (wen_pipe != '0);
          o_av_readdata[STAT_FULL_BIT] <= !o_cmd_ready;
        end
        REG_RD_CNT: o_av_readdata <= rd_count;
        REG_WR_CNT: o_av_readdata <= wr_count;
        default:    o_av_readdata <= '0;
      endcase
    end
  end

  // i_clk_sys arrives already multiplied and de-skewed against the memory clock
endmodule

// ### nts_sram_chk.sv
`timescale 1ns/10ps
// pin timing of the controller, seen from its ports only
module nts_sram_chk
#(
  parameter bit FLOWTHROUGH = 1'b0,
  parameter int LANE_COUNT  = 4
)
(
  input wire logic                  i_clk_sys,
  input wire logic                  i_nrst,
  input wire logic                  i_av_read,
  input wire logic                  i_av_write,
  input wire logic                  o_av_waitrequest,
  input wire logic                  o_cmd_ready,
  input wire logic                  o_user_read_valid,
  input wire logic [11:0]           o_memory_location_out,
  input wire logic                  o_memory_burst_continue,
  input wire logic [LANE_COUNT-1:0] o_memory_byte_enables_low,
  input wire logic                  o_mem_read_write,
  input wire logic                  o_mem_dq_oe
);
  // write data lag on the bus; read return adds two sync flops and an output flop
  localparam int WLAG = FLOWTHROUGH ? 1 : 2;
  localparam int RLAG = FLOWTHROUGH ? 4 : 5;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_write_lag: assert property (!o_mem_read_write |-> ##WLAG o_mem_dq_oe)
    else $error("write data not driven after write");
  a_drive_cause: assert property (o_mem_dq_oe |-> !$past(o_mem_read_write, WLAG))
    else $error("bus driven without write");
  a_read_return: assert property (o_user_read_valid |-> $past(o_mem_read_write, RLAG))
    else $error("read word without read");
  a_idle_lanes: assert property (o_mem_read_write |-> &o_memory_byte_enables_low)
    else $error("lane enabled outside write");
  a_burst_count:
    assert property (o_memory_burst_continue |-> o_memory_location_out ==
      {$past(o_memory_location_out[11:2]), $past(o_memory_location_out[1:0]) + 2'h1})
    else $error("burst address not advanced");
  a_reset_idle:
    assert property ($rose(i_nrst) |-> !o_cmd_ready && !o_mem_dq_oe && o_mem_read_write
      && &o_memory_byte_enables_low && !o_memory_burst_continue && o_av_waitrequest)
    else $error("outputs not idle after reset");
  a_wait_answer: assert property ((i_av_read || i_av_write) && o_av_waitrequest
    |=> !o_av_waitrequest) else $error("register access not answered");
  a_wait_short: assert property (!o_av_waitrequest |=> o_av_waitrequest)
    else $error("waitrequest low too long");
endmodule

bind nts_sram_ctrl nts_sram_chk #(.FLOWTHROUGH(FLOWTHROUGH), .LANE_COUNT(LANE_COUNT))
  nts_sram_chk_inst (.i_clk_sys, .i_nrst, .i_av_read, .i_av_write, .o_av_waitrequest,
  .o_cmd_ready, .o_user_read_valid, .o_memory_location_out, .o_memory_burst_continue,
  .o_memory_byte_enables_low, .o_mem_read_write, .o_mem_dq_oe);

// ### nts_sram_mem.sv
`timescale 1ns/10ps
// pipelined burst memory; flow-through timing is not modelled
module nts_sram_mem
(
  input  wire logic        i_clk_sys,
  input  wire logic [11:0] i_loc,
  input  wire logic        i_cont,
  input  wire logic [3:0]  i_lanes_n,
  input  wire logic        i_rw,
  input  wire logic [31:0] i_dq,
  output logic [31:0]      o_dq
);
  logic [31:0] cells [4096];
  logic [11:0] loc, at;
  logic [11:0] wloc [2];
  logic [3:0]  wlanes [2];
  logic [1:0]  wgo;
  logic        rgo;
  logic [31:0] rword;
  // no chip select, so idle cycles read the parked place; read words go out one
  // edge after the command is seen, mirroring the two-cycle write data lag; on
  // writes the bus shows the inverse of its last value so a stale word never matches
  always @(posedge i_clk_sys)
  begin
    at = i_cont ? {loc[11:2], loc[1:0] + 2'h1} : i_loc;
    loc <= at;
    wgo <= {wgo[0], !i_rw};
    wloc[0] <= at;
    wloc[1] <= wloc[0];
    wlanes[0] <= i_lanes_n;
    wlanes[1] <= wlanes[0];
    for (int b = 0; b < 4; b++)
      if (wgo[1] && !wlanes[1][b])
        cells[wloc[1]][8*b +: 8] <= i_dq[8*b +: 8];
    rgo <= i_rw;
    rword <= cells[at];
    o_dq <= rgo ? rword : ~o_dq;
  end
endmodule

// ### nts_sram_ctrl_tb.sv
`timescale 1ns/10ps
module nts_sram_ctrl_tb;
  import nts_pkg::*;
  logic        clk, nrst, cmd_valid, u_rd, u_cont, av_rd, av_wr;
  logic        rdy, rvalid, wreq, rw, cont_o, dq_oe;
  logic [3:0]  u_mask, av_a, lanes_n, av_be;
  logic [11:0] u_loc, loc_o, cur;
  logic [31:0] u_wd, av_wd, rdw, avq, av_rdata, m_dq, dq_o, bus;
  logic [31:0] ref_mem [int];
  logic [31:0] exp_q [$];
  int          fail_count, samples_checked, n_rd, n_wr;

  ////////////////////////////////////////
  // 40 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  nts_sram_ctrl nts_sram_ctrl_inst (.i_clk_sys(clk), .i_nrst(nrst), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(rdy), .i_user_location(u_loc), .i_user_read(u_rd),
    .i_user_burst_continue(u_cont), .i_user_write_word(u_wd), .i_user_byte_mask(u_mask),
    .o_user_read_word(rdw), .o_user_read_valid(rvalid), .i_av_address(av_a),
    .i_av_read(av_rd), .i_av_write(av_wr), .i_av_writedata(av_wd), .i_av_byteenable(av_be),
    .o_av_readdata(av_rdata), .o_av_waitrequest(wreq), .o_memory_location_out(loc_o),
    .o_memory_burst_continue(cont_o), .o_memory_byte_enables_low(lanes_n),
    .o_mem_read_write(rw), .i_mem_dq(bus), .o_mem_dq(dq_o), .o_mem_dq_oe(dq_oe));
  nts_sram_mem nts_sram_mem_inst (.i_clk_sys(clk), .i_loc(loc_o), .i_cont(cont_o),
    .i_lanes_n(lanes_n), .i_rw(rw), .i_dq(bus), .o_dq(m_dq));
  // shared data bus: the controller wins only while it drives
  assign bus = dq_oe ? dq_o : m_dq;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hang;
    check("wait", 32'h0, 32'h1);
    tally_and_finish();
  endtask

  // one register access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      av_a <= a;
      av_wd <= d;
      av_rd <= !wr;
      av_wr <= wr;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (wreq !== 1'b0 && n < 50);
      if (wreq !== 1'b0)
        hang();
      avq = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic put(input logic r, input logic c, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] m);
    cmd_valid <= 1'b1;
    u_rd <= r;
    u_cont <= c;
    u_loc <= a;
    u_wd <= d;
    u_mask <= m;
  endtask

  // wait for the taking edge, then update the reference memory
  task automatic take;
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (rdy !== 1'b1 && n < 200);
      if (rdy !== 1'b1)
        hang();
      cur = u_cont ? {cur[11:2], cur[1:0] + 2'h1} : u_loc;
      n_rd += u_rd;
      n_wr += !u_rd;
      if (u_rd)
        exp_q.push_back(ref_mem[cur]);
      else
        for (int b = 0; b < 4; b++)
          if (u_mask[b])
            ref_mem[cur][8*b +: 8] = u_wd[8*b +: 8];
    end
  endtask

  // every returned word is compared with the reference in order
  always @(posedge clk)
    if (rvalid === 1'b1)
    begin
      // a word nobody asked for is a fault in itself
      if (exp_q.size() == 0)
        check("read extra", 32'h1, 32'h0);
      else
        check("read", rdw, exp_q.pop_front());
    end

  initial
  begin
    {nrst, cmd_valid, u_rd, u_cont, av_rd, av_wr} = '0;
    {u_loc, u_wd, u_mask, av_a, av_wd, cur} = '0;
    {fail_count, samples_checked, n_rd, n_wr} = '0;
    av_be = 4'hf;
    void'($urandom(15));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    av(1'b1, 4'h3, 32'hffffffff);
    av(1'b0, 4'h3, 32'h0);
    check("unmapped", avq, 32'h0);
    av(1'b0, REG_CTRL, 32'h0);
    check("ctrl", avq, 32'h1);
    // run bit lives in lane 0: a write without that lane must not stop the drain
    av_be <= 4'he;
    av(1'b1, REG_CTRL, 32'h0);
    av_be <= 4'hf;
    av(1'b0, REG_CTRL, 32'h0);
    check("ctrl lane", avq, 32'h1);
    $display("test registers done");
    // drain stopped first, so the queue fills and refuses the last write
    av(1'b1, REG_CTRL, 32'h0);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 17; i++)
      begin
        put(p[0], i % 4 != 0, i % 4 ? 12'($urandom()) : 12'h100 + 12'(i), $urandom(),
          p ? 4'($urandom()) : 4'hf);
        if (p == 0 && i == 16)
        begin
          repeat (3) @(posedge clk);
          check("ready", {31'h0, rdy}, 32'h0);
          av(1'b0, REG_STATUS, 32'h0);
          check("status", avq & 32'h31f, 32'h310);
          av(1'b1, REG_CTRL, 32'h1);
        end
        take();
      end
    $display("test bursts done");
    // writes and reads back to back with no idle cycle between them
    for (int i = 0; i < 16; i++)
    begin
      put(i[0], 1'b0, 12'h100 + 12'((i[0] ? i + 8 : i) % 16), $urandom(), 4'($urandom()));
      take();
    end
    cmd_valid <= 1'b0;
    for (int n = 0; n < 100 && exp_q.size() != 0; n++)
      @(posedge clk);
    check("left", 32'(exp_q.size()), 32'h0);
    av(1'b0, REG_RD_CNT, 32'h0);
    check("reads", avq, 32'(n_rd));
    av(1'b0, REG_WR_CNT, 32'h0);
    check("writes", avq, 32'(n_wr));
    $display("test mixed done");
    tally_and_finish();
  end
endmodule
